// ==== bench/tb.sv ====
// Self-checking bench for the traffic-channel test loop block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("mismatch at %0t got %0h exp %0h", $time, a, e); end end
module tb import tlb_pkg::*;;
	logic ref_clk, resetn, avs_read, avs_write, call_drop, avs_waitrequest, dl_valid, dl_bfi;
	logic dl_ufi, dl_facch, dl_sacch, ul_valid, ul_good, loop_on, phase_odd, ratscch_en, ack_valid;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [2:0] dl_slot, ul_slot;
	logic [1:0] dl_sid, dl_cmi, dl_cmc, ul_cmr, ul_cmi, ul_mode, ack_code;
	logic [TLB_PW-1:0] dl_bits, ul_bits;
	logic [5:0] ft [6] = '{6'h20, 6'h10, 6'h00, 6'h28, 6'h24, 6'h22};
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	localparam logic [TLB_PW-1:0] ALT = {57{2'b01}};
	localparam logic [TLB_PW-1:0] DAT = {6{19'h5A3C1}};
	tlb_sim_model sim (.ref_clk, .dl_valid, .dl_slot, .dl_sid, .dl_bfi, .dl_ufi, .dl_facch,
		.dl_sacch, .dl_cmi, .dl_cmc, .dl_bits);
	tlb_loop uut (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .call_drop, .dl_valid, .dl_slot, .dl_sid, .dl_bfi,
		.dl_ufi, .dl_facch, .dl_sacch, .dl_cmi, .dl_cmc, .dl_bits, .ul_valid, .ul_slot,
		.ul_bits, .ul_good, .ul_cmr, .ul_cmi, .ul_mode, .loop_on, .phase_odd, .ratscch_en,
		.ack_valid, .ack_code);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Some 115 cycles are needed; the 3000-cycle ceiling leaves ample margin
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	task end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk
	// Answer strobe stands only in the cycle after the taking edge
	task cmd(input logic [31:0] d, input logic v, input logic [1:0] c);
		bus(1'b1, TLB_OFF_CMD, d);
		#1;
		`CHK(ack_valid, v)
		if (v) `CHK(ack_code, c)
	endtask : cmd
	task frm(input logic [2:0] s, input logic [5:0] f, input logic [3:0] m, input logic v,
		input logic [TLB_PW-1:0] e);
		sim.send(s, f, m, DAT);
		#1;
		`CHK(ul_valid, v)
		if (v) `CHK(ul_bits, e)
	endtask : frm
	task drop;
		@(posedge ref_clk);
		call_drop <= 1'b1;
		@(posedge ref_clk);
		call_drop <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(loop_on, 1'b0)
	endtask : drop
	initial begin
		{resetn, avs_read, avs_write, call_drop, avs_address, avs_writedata} = '0;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		rchk(TLB_OFF_CHAN, TLB_RST_CHAN);
		rchk(TLB_OFF_SLOT, TLB_RST_SLOT);
		rchk(5'h10, 32'h0);
		rchk(TLB_OFF_STAT, 32'h80);
		`CHK(ratscch_en, 1'b1)
		$display("test reset done");
		cmd(32'h00, 1'b0, TLB_ACK_NONE);
		bus(1'b1, TLB_OFF_CHAN, 32'h1);
		cmd(32'h00, 1'b0, TLB_ACK_NONE);
		bus(1'b1, TLB_OFF_CHAN, {28'h0, TLB_TCH_HS, 1'b1});
		cmd(32'h00, 1'b1, TLB_ACK_CLOSE);
		rchk(TLB_OFF_STAT, 32'h181);
		for (int i = 0; i < 6; i++) begin
			frm(3'h0, ft[i], 4'h0, 1'b1, i == 0 ? DAT : '0);
		end
		cmd(32'h04, 1'b0, TLB_ACK_NONE);
		drop();
		rchk(TLB_OFF_STAT, 32'h180);
		frm(3'h0, 6'h20, 4'h0, 1'b0, '0);
		$display("test loop f done");
		bus(1'b1, TLB_OFF_CHAN, {28'h0, TLB_TCH_AFS, 1'b1});
		cmd(32'h04, 1'b1, TLB_ACK_CLOSE);
		@(posedge ref_clk);
		#1;
		`CHK(ratscch_en, 1'b0)
		`CHK(phase_odd, 1'b1)
		frm(3'h0, 6'h28, 4'hB, 1'b1, ALT);
		`CHK(ul_good, 1'b1)
		`CHK({ul_cmr, ul_cmi}, 4'hB)
		`CHK(ul_mode, 2'h3)
		frm(3'h0, 6'h22, 4'h4, 1'b1, '0);
		`CHK({ul_mode, ul_cmr, ul_cmi}, 6'h3B)
		drop();
		$display("test loop i done");
		bus(1'b1, TLB_OFF_CHAN, 32'h1);
		bus(1'b1, TLB_OFF_SLOT, 32'h0002_060F);
		rchk(TLB_OFF_SLOT, 32'h0002_060F);
		cmd(32'hE9, 1'b1, TLB_ACK_NEG);
		`CHK(loop_on, 1'b0)
		cmd(32'h69, 1'b1, TLB_ACK_CLOSE);
		rchk(TLB_OFF_STAT, 32'h1B5);
		bus(1'b1, TLB_OFF_CHAN, 32'h3);
		frm(3'h3, 6'h28, 4'h0, 1'b1, DAT);
		`CHK(loop_on, 1'b1)
		`CHK(ul_slot, 3'h2)
		frm(3'h1, 6'h20, 4'h0, 1'b0, '0);
		frm(3'h3, 6'h01, 4'h0, 1'b0, '0);
		cmd(32'h1D, 1'b1, TLB_ACK_CLOSE);
		frm(3'h3, 6'h20, 4'h0, 1'b0, '0);
		frm(3'h1, 6'h20, 4'h0, 1'b1, DAT);
		`CHK(ul_slot, 3'h1)
		frm(3'h2, 6'h28, 4'h0, 1'b1, '0);
		`CHK(ul_slot, 3'h2)
		cmd(32'h02, 1'b1, TLB_ACK_OPEN);
		frm(3'h1, 6'h20, 4'h0, 1'b0, '0);
		$display("test multi-slot done");
		end_sim();
	end
endmodule : tb
`default_nettype wire

// ==== bench/tlb_sim_model.sv ====
// Far-side simulator model: downlink frame source for the loop block
`timescale 1ns/1ps
`default_nettype none
module tlb_sim_model import tlb_pkg::*; (
	input wire logic ref_clk,
	output logic dl_valid,
	output logic [2:0] dl_slot,
	output logic [1:0] dl_sid,
	output logic dl_bfi,
	output logic dl_ufi,
	output logic dl_facch,
	output logic dl_sacch,
	output logic [1:0] dl_cmi,
	output logic [1:0] dl_cmc,
	output logic [TLB_PW-1:0] dl_bits
);
	initial begin
		dl_valid = 1'b0;
		{dl_slot, dl_sid, dl_bfi, dl_ufi, dl_facch, dl_sacch, dl_cmi, dl_cmc, dl_bits} = '0;
	end
	// Fields flip after the strobe so stale data never passes for a frame
	task send(input logic [2:0] s, input logic [5:0] f, input logic [3:0] m,
		input logic [TLB_PW-1:0] b);
		@(posedge ref_clk);
		dl_valid <= 1'b1;
		{dl_slot, dl_sid, dl_bfi, dl_ufi, dl_facch, dl_sacch, dl_cmi, dl_cmc, dl_bits} <= {s, f, m, b};
		@(posedge ref_clk);
		dl_valid <= 1'b0;
		{dl_slot, dl_sid, dl_bfi, dl_ufi, dl_facch, dl_sacch, dl_cmi, dl_cmc, dl_bits} <= ~{s, f, m, b};
	endtask : send
endmodule : tlb_sim_model
`default_nettype wire

// ==== inc/tlb_pkg.sv ====
// Constants and types for the traffic-channel test loop block
package tlb_pkg;
	localparam int TLB_PW = 114;
	localparam int TLB_AW = 5;
	// Byte offsets of the register words
	localparam logic [4:0] TLB_OFF_CHAN = 5'h00;
	localparam logic [4:0] TLB_OFF_CMD = 5'h04;
	localparam logic [4:0] TLB_OFF_STAT = 5'h08;
	localparam logic [4:0] TLB_OFF_SLOT = 5'h0C;
	// Channel register fields
	localparam int TLB_CH_ON = 0;
	localparam int TLB_CH_TYP = 1;
	// Channel type codes
	localparam logic [2:0] TLB_TCH_FS = 3'h0;
	localparam logic [2:0] TLB_TCH_EFS = 3'h1;
	localparam logic [2:0] TLB_TCH_HS = 3'h2;
	localparam logic [2:0] TLB_TCH_AFS = 3'h3;
	localparam logic [2:0] TLB_TCH_AHS = 3'h4;
	// Slot register fields
	localparam int TLB_SL_CFG = 0;
	localparam int TLB_SL_BID = 8;
	localparam int TLB_SL_MAIN = 16;
	// Command register fields
	localparam int TLB_CM_OP = 0;
	localparam int TLB_CM_TYP = 2;
	localparam int TLB_CM_MECH = 4;
	localparam int TLB_CM_SEL = 5;
	localparam logic [1:0] TLB_OP_CLS = 2'h0;
	localparam logic [1:0] TLB_OP_CLM = 2'h1;
	localparam logic [1:0] TLB_OP_OPM = 2'h2;
	// Answer codes
	localparam logic [1:0] TLB_ACK_NONE = 2'h0;
	localparam logic [1:0] TLB_ACK_CLOSE = 2'h1;
	localparam logic [1:0] TLB_ACK_OPEN = 2'h2;
	localparam logic [1:0] TLB_ACK_NEG = 2'h3;
	// Reset values
	localparam logic [31:0] TLB_RST_CHAN = 32'h0000_0000;
	localparam logic [31:0] TLB_RST_SLOT = 32'h0000_0101;
	localparam logic [2:0] TLB_RST_MODE = 3'h0;
	typedef enum logic [1:0] {TLB_F, TLB_I, TLB_G, TLB_H} tlb_loop_e;
endpackage : tlb_pkg

// ==== logic/tlb_loop.sv ====
// Traffic-channel test loop: command handling and frame looping
// Contract
// - Ignore close without channel or when looped
// - Loop F needs half-rate speech channel
// - Half-rate active: close loop, send acknowledgement
// - Loop F: valid SID frames looped uplink
// - Loop F: bad or erased SID sends zeros
// - Loop F: FACCH frame sends all zeros
// - Loop I needs adaptive speech channel
// - Loop I: CMI to CMR, CMC to CMI
// - Loop I close assumes odd phase
// - Loop I: uplink mode from decoded CMC
// - Loop I: alternating pattern, first one, good
// - Loop I disables RATSCCH handling entirely
// - Loop I delay fixed, one cycle
// - Loop I non-speech: zeros, previous mode, CMR
// - Loop G: burst bits looped, not SACCH/idle
// - Mechanism 1: selected slot to main slot
// - Mechanism 2: bidirectional slots only looped
// - Multi-slot loops keep downlink order
// - Open command or call drop opens all (the open command here opens multi-slot loops only)
// - Level, assignment, handover leave loops unchanged
// - Mechanism 1 bad slot: negative ack, no change
// - New multi-slot close replaces the old
`timescale 1ns/1ps
`default_nettype none
module tlb_loop import tlb_pkg::*; #(
	parameter int PW = TLB_PW
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [TLB_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic call_drop,
	input wire logic dl_valid,
	input wire logic [2:0] dl_slot,
	input wire logic [1:0] dl_sid,
	input wire logic dl_bfi,
	input wire logic dl_ufi,
	input wire logic dl_facch,
	input wire logic dl_sacch,
	input wire logic [1:0] dl_cmi,
	input wire logic [1:0] dl_cmc,
	input wire logic [PW-1:0] dl_bits,
	output logic ul_valid,
	output logic [2:0] ul_slot,
	output logic [PW-1:0] ul_bits,
	output logic ul_good,
	output logic [1:0] ul_cmr,
	output logic [1:0] ul_cmi,
	output logic [1:0] ul_mode,
	output logic loop_on,
	output logic phase_odd,
	output logic ratscch_en,
	output logic ack_valid,
	output logic [1:0] ack_code
);
	function automatic logic [PW-1:0] alt_pat();
		logic [PW-1:0] p;
		p = '0;
		for (int i = 0; i < PW; i++) begin
			p[i] = ~i[0];
		end
		return p;
	endfunction : alt_pat

	logic [31:0] chan_q, slot_q;
	logic closed_q, mech_q, multi_q;
	tlb_loop_e type_q;
	logic [2:0] sel_q;
	logic [1:0] last_ack_q;
	logic take, rq, cmd_take;
	logic [1:0] op;
	tlb_loop_e ctyp;
	logic cmech;
	logic [2:0] csel, chtyp;
	logic tch_on, hs_on, amr_on, bad_f;

	assign rq = avs_read | avs_write;
	assign take = rq & ~avs_waitrequest;
	assign cmd_take = take & avs_write & (avs_address == TLB_OFF_CMD);
	assign op = avs_writedata[TLB_CM_OP+:2];
	assign ctyp = tlb_loop_e'(avs_writedata[TLB_CM_TYP+:2]);
	assign cmech = avs_writedata[TLB_CM_MECH];
	assign csel = avs_writedata[TLB_CM_SEL+:3];
	assign tch_on = chan_q[TLB_CH_ON];
	assign chtyp = chan_q[TLB_CH_TYP+:3];
	assign hs_on = chtyp == TLB_TCH_HS;
	assign amr_on = chtyp == TLB_TCH_AFS || chtyp == TLB_TCH_AHS;
	assign bad_f = dl_facch | dl_bfi | dl_ufi | (dl_sid != 2'h2);

	// One wait cycle per access, then a single-cycle answer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(rq & avs_waitrequest);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= '0;
		end else if (rq & avs_waitrequest) begin
			case (avs_address)
				TLB_OFF_CHAN: avs_readdata <= chan_q;
				TLB_OFF_SLOT: avs_readdata <= slot_q;
				TLB_OFF_STAT: avs_readdata <= {22'h0, last_ack_q, phase_odd,
					sel_q, mech_q, type_q, closed_q};
				default: avs_readdata <= '0;
			endcase
		end
	end

	// Config words; a write never opens or closes a loop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			chan_q <= TLB_RST_CHAN;
			slot_q <= TLB_RST_SLOT;
		end else if (take & avs_write) begin
			if (avs_address == TLB_OFF_CHAN) begin
				chan_q <= avs_writedata;
			end
			if (avs_address == TLB_OFF_SLOT) begin
				slot_q <= avs_writedata;
			end
		end
	end

	// Loop state record
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			closed_q <= 1'b0;
			multi_q <= 1'b0;
			type_q <= TLB_F;
			mech_q <= 1'b0;
			sel_q <= 3'h0;
			phase_odd <= 1'b1;
			ack_valid <= 1'b0;
			ack_code <= TLB_ACK_NONE;
			last_ack_q <= TLB_ACK_NONE;
		end else begin
			ack_valid <= 1'b0;
			if (call_drop) begin
				closed_q <= 1'b0;
				multi_q <= 1'b0;
			end else if (cmd_take) begin
				case (op)
					TLB_OP_CLS: begin
						if (tch_on && !closed_q && ((ctyp == TLB_F && hs_on) ||
							(ctyp == TLB_I && amr_on))) begin
							closed_q <= 1'b1;
							multi_q <= 1'b0;
							type_q <= ctyp;
							ack_valid <= 1'b1;
							ack_code <= TLB_ACK_CLOSE;
							last_ack_q <= TLB_ACK_CLOSE;
							if (ctyp == TLB_I) begin
								phase_odd <= 1'b1;
							end
						end
					end
					TLB_OP_CLM: begin
						// A closed multi-slot loop may be replaced
						if (tch_on && (!closed_q || multi_q) &&
							(ctyp == TLB_G || ctyp == TLB_H)) begin
							if (!cmech && !slot_q[TLB_SL_CFG+csel]) begin
								ack_valid <= 1'b1;
								ack_code <= TLB_ACK_NEG;
								last_ack_q <= TLB_ACK_NEG;
							end else begin
								closed_q <= 1'b1;
								multi_q <= 1'b1;
								type_q <= ctyp;
								mech_q <= cmech;
								sel_q <= csel;
								ack_valid <= 1'b1;
								ack_code <= TLB_ACK_CLOSE;
								last_ack_q <= TLB_ACK_CLOSE;
							end
						end
					end
					TLB_OP_OPM: begin
						if (closed_q && multi_q) begin
							closed_q <= 1'b0;
							multi_q <= 1'b0;
							ack_valid <= 1'b1;
							ack_code <= TLB_ACK_OPEN;
							last_ack_q <= TLB_ACK_OPEN;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Status levels derived from the record
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			loop_on <= 1'b0;
			ratscch_en <= 1'b1;
		end else begin
			loop_on <= closed_q;
			ratscch_en <= ~(closed_q & (type_q == TLB_I));
		end
	end

	// Frame path: fixed one-cycle latency, in arrival order
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ul_valid <= 1'b0;
			ul_slot <= 3'h0;
			ul_bits <= '0;
			ul_good <= 1'b0;
			ul_cmr <= 2'h0;
			ul_cmi <= 2'h0;
			ul_mode <= TLB_RST_MODE[1:0];
		end else begin
			ul_valid <= 1'b0;
			if (dl_valid && closed_q) begin
				case (type_q)
					TLB_F: begin
						ul_valid <= 1'b1;
						ul_slot <= dl_slot;
						ul_good <= 1'b1;
						// Erasure and FACCH both signalled as zeros
						ul_bits <= bad_f ? '0 : dl_bits;
					end
					TLB_I: begin
						ul_valid <= 1'b1;
						ul_slot <= dl_slot;
						ul_good <= 1'b1;
						if (dl_facch) begin
							ul_bits <= '0;
							ul_cmi <= ul_mode;
						end else begin
							ul_bits <= alt_pat();
							ul_cmr <= dl_cmi;
							ul_cmi <= dl_cmc;
							ul_mode <= dl_cmc;
						end
					end
					default: begin
						// SACCH and idle bursts stay on the normal path
						if (!dl_sacch) begin
							if (!mech_q && dl_slot == sel_q) begin
								ul_valid <= 1'b1;
								ul_slot <= slot_q[TLB_SL_MAIN+:3];
							end else if (mech_q && slot_q[TLB_SL_BID+dl_slot]) begin
								ul_valid <= 1'b1;
								ul_slot <= dl_slot;
							end
							ul_good <= 1'b1;
							// H zeroes bad frames and FACCH (FACCH has no set answer); G loops both as received
							if (type_q == TLB_H && (dl_bfi || dl_facch)) begin
								ul_bits <= '0;
							end else begin
								ul_bits <= dl_bits;
							end
						end
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic cls_ok;
	assign cls_ok = cmd_take && op == TLB_OP_CLS && tch_on && !closed_q && !call_drop;

	property p_ign_off;
		cmd_take && !tch_on && !call_drop && op != TLB_OP_OPM
			|=> !ack_valid && !$rose(closed_q);
	endproperty
	a_ign_off: assert property (p_ign_off) else $error("close taken without channel");

	property p_f_hs;
		cls_ok && ctyp == TLB_F && !hs_on |=> !closed_q && !ack_valid;
	endproperty
	a_f_hs: assert property (p_f_hs) else $error("loop F closed off half rate");

	property p_f_ack;
		cls_ok && ctyp == TLB_F && hs_on |=> closed_q && ack_valid && ack_code == TLB_ACK_CLOSE;
	endproperty
	a_f_ack: assert property (p_f_ack) else $error("loop F close not acknowledged");

	property p_i_amr;
		cls_ok && ctyp == TLB_I && !amr_on |=> !closed_q;
	endproperty
	a_i_amr: assert property (p_i_amr) else $error("loop I closed off adaptive");

	sequence s_f_frame;
		dl_valid && closed_q && type_q == TLB_F;
	endsequence
	property p_f_loop;
		s_f_frame ##0 !bad_f |=> ul_valid && ul_bits == $past(dl_bits);
	endproperty
	a_f_loop: assert property (p_f_loop) else $error("valid SID not looped");

	property p_f_zero;
		s_f_frame ##0 bad_f |=> ul_valid && ul_bits == '0;
	endproperty
	a_f_zero: assert property (p_f_zero) else $error("bad frame not zeroed");

	sequence s_i_speech;
		dl_valid && closed_q && type_q == TLB_I && !dl_facch;
	endsequence
	property p_i_inband;
		s_i_speech |=> ul_cmr == $past(dl_cmi) && ul_cmi == $past(dl_cmc) && ul_mode == ul_cmi;
	endproperty
	a_i_inband: assert property (p_i_inband) else $error("in-band bits not looped");

	property p_i_pat;
		s_i_speech |=> ul_valid && ul_good && ul_bits[0] && !ul_bits[1];
	endproperty
	a_i_pat: assert property (p_i_pat) else $error("loop I pattern wrong");

	property p_ratscch;
		closed_q && type_q == TLB_I ##1 closed_q && type_q == TLB_I |-> !ratscch_en;
	endproperty
	a_ratscch: assert property (p_ratscch) else $error("RATSCCH active in loop I");

	property p_drop;
		call_drop |=> !closed_q && !ack_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("drop did not open silently");

	property p_neg;
		cmd_take && op == TLB_OP_CLM && tch_on && !closed_q && !call_drop && !cmech &&
			(ctyp == TLB_G || ctyp == TLB_H) && !slot_q[TLB_SL_CFG+csel]
			|=> ack_code == TLB_ACK_NEG && !closed_q;
	endproperty
	a_neg: assert property (p_neg) else $error("bad slot not refused");

	property p_f_facch;
		s_f_frame ##0 dl_facch |=> ul_valid && ul_bits == '0;
	endproperty
	a_f_facch: assert property (p_f_facch) else $error("FACCH frame not zeroed");

	property p_i_facch;
		dl_valid && closed_q && type_q == TLB_I && dl_facch |=> ul_valid && ul_bits == '0 &&
			ul_cmi == $past(ul_mode) && $stable(ul_cmr) && $stable(ul_mode);
	endproperty
	a_i_facch: assert property (p_i_facch) else $error("loop I non-speech frame wrong");

	property p_m1;
		dl_valid && closed_q && multi_q && !mech_q && !dl_sacch && dl_slot == sel_q
			|=> ul_valid && ul_slot == $past(slot_q[TLB_SL_MAIN+:3]);
	endproperty
	a_m1: assert property (p_m1) else $error("selected slot not looped to main");

	property p_m2;
		dl_valid && closed_q && multi_q && mech_q && !dl_sacch
			|=> ul_valid == $past(slot_q[TLB_SL_BID+dl_slot]);
	endproperty
	a_m2: assert property (p_m2) else $error("bidirectional looping wrong");

	property p_sacch;
		dl_valid && closed_q && multi_q && dl_sacch |=> !ul_valid;
	endproperty
	a_sacch: assert property (p_sacch) else $error("SACCH burst looped");

	property p_replace;
		cmd_take && op == TLB_OP_CLM && tch_on && closed_q && multi_q && !call_drop &&
			(ctyp == TLB_G || ctyp == TLB_H) && (cmech || slot_q[TLB_SL_CFG+csel])
			|=> mech_q == $past(cmech) && sel_q == $past(csel) && type_q == $past(ctyp);
	endproperty
	a_replace: assert property (p_replace) else $error("multi-slot close not replaced");

	property p_open;
		cmd_take && op == TLB_OP_OPM && closed_q && multi_q && !call_drop
			|=> !closed_q && ack_valid && ack_code == TLB_ACK_OPEN;
	endproperty
	a_open: assert property (p_open) else $error("multi-slot open not acknowledged");

	property p_cfg;
		take && avs_write && avs_address != TLB_OFF_CMD && !call_drop
			|=> $stable(closed_q) && $stable(type_q);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config write changed loop state");
endmodule : tlb_loop
`default_nettype wire
